/* File: design/ptm_top.sv */
// Periodic timer with compare, PWM, single pulse and timer modes on AHB-Lite
// Assumes single word transfers, one hclk domain, trigger pin asynchronous
`timescale 1ns/1ps
module ptm_top
  import ptm_pkg::*;
#(
  parameter int unsigned INST = 0
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic external_trigger_pin,
  output logic timer_out,
  output logic timer_out_oe,
  output logic compare_a_flag,
  output logic compare_p_flag
);

  localparam int unsigned W = ptm_width(INST);

  function automatic logic [W:0] ptm_limit(input logic [W-1:0] v);
    ptm_limit = (v == '0) ? {1'b1, {W{1'b0}}} : {1'b0, v};
  endfunction

  ptm_ctrl_s ctrl_q;
  ptm_ctrl_s ctrl_rd;
  ptm_op_e op;
  logic run_q;
  logic run_prev_q;
  logic run_d;
  logic run_rise;
  logic [W-1:0] cnt_q;
  logic [W-1:0] compare_a_value_q;
  logic [W-1:0] per_q;
  logic [W:0] cnt_inc;
  logic [1:0] flag_q;
  logic [1:0] flag_set;
  logic [1:0] flag_clr;
  logic [PTM_PRE_W-1:0] pre_q;
  logic [PTM_PRE_W-1:0] mask;
  logic tick;
  logic step;
  logic a_hit;
  logic a_lim;
  logic p_hit;
  logic clr_now;
  logic cm_out_q;
  logic pin_q;
  logic pin_d;
  logic oe_q;
  logic lvl;
  logic pwm_act;
  logic [1:0] fn;
  logic trig_edge;
  logic acc;
  logic wr_q;
  logic [7:0] wr_addr_q;
  logic [31:0] rd_q;
  logic [31:0] rd_d;
  logic wr_ctrl;
  logic wr_compa;
  logic wr_period;
  logic wr_flags;

  // Bus slave: zero wait states, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rd_q;
  assign acc = hsel && hready && htrans[1] && (hsize == PTM_HSIZE_WORD);

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      wr_addr_q <= 8'h00;
    end else begin
      wr_q <= acc && hwrite;
      if (acc) begin
        wr_addr_q <= haddr[7:0];
      end
    end
  end

  assign wr_ctrl = wr_q && (wr_addr_q == PTM_OFF_CTRL);
  assign wr_compa = wr_q && (wr_addr_q == PTM_OFF_COMPA);
  assign wr_period = wr_q && (wr_addr_q == PTM_OFF_PERIOD);
  assign wr_flags = wr_q && (wr_addr_q == PTM_OFF_FLAGS);

  always_comb begin
    ctrl_rd = ctrl_q;
    ctrl_rd.counter_run = run_q;
    case (haddr[7:0])
      PTM_OFF_CTRL: rd_d = {20'h0_0000, ctrl_rd};
      PTM_OFF_COMPA: rd_d = 32'(compare_a_value_q);
      PTM_OFF_PERIOD: rd_d = 32'(per_q);
      PTM_OFF_COUNT: rd_d = 32'(cnt_q);
      PTM_OFF_FLAGS: rd_d = {30'h0000_0000, flag_q};
      PTM_OFF_STATUS: rd_d = {30'h0000_0000, oe_q, pin_q};
      default: rd_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rd_q <= 32'h0000_0000;
    end else if (acc && !hwrite) begin
      rd_q <= rd_d;
    end
  end

  // Configuration registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_q <= ptm_ctrl_s'(PTM_CTRL_RST);
    end else if (wr_ctrl) begin
      ctrl_q <= ptm_ctrl_s'(hwdata[11:0]);
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      compare_a_value_q <= '0;
    end else if (wr_compa) begin
      compare_a_value_q <= hwdata[W-1:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      per_q <= '0;
    end else if (wr_period) begin
      per_q <= hwdata[W-1:0];
    end
  end

  assign fn = {ctrl_q.output_function_hi, ctrl_q.output_function_lo};
  assign op = ptm_decode({ctrl_q.mode_select_hi, ctrl_q.mode_select_lo}, fn);
  assign lvl = ctrl_q.output_initial_level ^ ctrl_q.output_polarity_invert;

  // Timer clock: one tick every 2^clk_sel hclk cycles
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pre_q <= '0;
    end else begin
      pre_q <= pre_q + PTM_PRE_W'(1);
    end
  end

  assign mask = ptm_tick_mask(ctrl_q.clk_sel);
  assign tick = ((pre_q & mask) == mask);

  ptm_sync_edge u_trig (
    .clk(hclk),
    .rst_n(hresetn),
    .pin(external_trigger_pin),
    .fall_sel(ctrl_q.trig_fall),
    .edge_p(trig_edge)
  );

  // Run bit: software write, then hardware clear, then trigger set
  always_comb begin
    run_d = run_q;
    if (wr_ctrl) begin
      run_d = hwdata[0];
    end
    if (op == PTM_OP_PULSE && a_hit) begin
      run_d = 1'b0;
    end
    if (op == PTM_OP_PULSE && trig_edge) begin
      run_d = 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      run_q <= 1'b0;
      run_prev_q <= 1'b0;
    end else begin
      run_q <= run_d;
      run_prev_q <= run_q;
    end
  end

  assign run_rise = run_q && !run_prev_q;

  // Match detection against the next count value
  assign step = run_q && !run_rise && tick;
  assign cnt_inc = {1'b0, cnt_q} + {{W{1'b0}}, 1'b1};
  assign a_hit = step && (compare_a_value_q != '0) && (cnt_inc == {1'b0, compare_a_value_q});
  assign a_lim = step && (cnt_inc == ptm_limit(compare_a_value_q));
  assign p_hit = step && (cnt_inc == ptm_limit(per_q));

  always_comb begin
    case (op)
      PTM_OP_CMP: clr_now = ctrl_q.clear_source_select ? a_lim : p_hit;
      PTM_OP_TMR: clr_now = ctrl_q.clear_source_select ? a_lim : p_hit;
      PTM_OP_PWM: clr_now = p_hit;
      PTM_OP_PULSE: clr_now = 1'b0;
      default: clr_now = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= '0;
    end else if (run_rise) begin
      cnt_q <= '0;
    end else if (step) begin
      if (clr_now) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_inc[W-1:0];
      end
    end
  end

  // Sticky flags, set wins over a clearing write
  always_comb begin
    flag_set = 2'b00;
    flag_set[PTM_FLAG_A] = a_hit;
    case (op)
      PTM_OP_CMP: flag_set[PTM_FLAG_P] = p_hit && !ctrl_q.clear_source_select;
      PTM_OP_TMR: flag_set[PTM_FLAG_P] = p_hit && !ctrl_q.clear_source_select;
      PTM_OP_PWM: flag_set[PTM_FLAG_P] = p_hit;
      default: flag_set[PTM_FLAG_P] = 1'b0;
    endcase
    flag_clr = wr_flags ? hwdata[1:0] : 2'b00;
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flag_q <= PTM_FLAG_RST;
    end else begin
      flag_q <= (flag_q & ~flag_clr) | flag_set;
    end
  end

  assign compare_a_flag = flag_q[PTM_FLAG_A];
  assign compare_p_flag = flag_q[PTM_FLAG_P];

  // Compare-match output state
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cm_out_q <= 1'b0;
    end else if (run_rise) begin
      cm_out_q <= ctrl_q.output_initial_level;
    end else if (op == PTM_OP_CMP && a_hit) begin
      case (fn)
        PTM_FN_1: cm_out_q <= 1'b0;
        PTM_FN_2: cm_out_q <= 1'b1;
        PTM_FN_3: cm_out_q <= ~cm_out_q;
        default: cm_out_q <= cm_out_q;
      endcase
    end
  end

  // Pin level and enable
  assign pwm_act = run_q && (cnt_q < compare_a_value_q);

  always_comb begin
    case (op)
      PTM_OP_CMP: pin_d = cm_out_q;
      PTM_OP_TMR: pin_d = 1'b0;
      PTM_OP_PWM: begin
        case (fn)
          PTM_FN_0: pin_d = 1'b0;
          PTM_FN_1: pin_d = 1'b1;
          default: pin_d = pwm_act ? lvl : ~lvl;
        endcase
      end
      PTM_OP_PULSE: pin_d = run_q ? lvl : ~lvl;
      default: pin_d = 1'b0;
    endcase
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      pin_q <= pin_d;
      oe_q <= (op != PTM_OP_TMR);
    end
  end

  assign timer_out = pin_q;
  assign timer_out_oe = oe_q;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  a_tmr_pin_off: assert property ((op == PTM_OP_TMR) |=> !timer_out_oe)
    else $error("timer mode drives the pin");

  a_pwm_clr_ignored: assert property (
    (op == PTM_OP_PWM && ctrl_q.clear_source_select && p_hit && !run_rise)
      |=> (cnt_q == '0) && flag_q[PTM_FLAG_P])
    else $error("pwm period match did not clear counter");

  a_pwm_a_flag: assert property ((op == PTM_OP_PWM && a_hit) |=> flag_q[PTM_FLAG_A])
    else $error("pwm compare a flag missing");

  a_pwm_forced_runs: assert property (
    (op == PTM_OP_PWM && fn == PTM_FN_0 && step && !clr_now)
      |=> (cnt_q != $past(cnt_q)) && !timer_out)
    else $error("forced pwm stopped counting or pin not low");

  a_pwm_full_wrap: assert property (
    (op == PTM_OP_PWM && per_q == '0 && step && cnt_q == {W{1'b1}})
      |=> cnt_q == '0)
    else $error("zero period did not give full count");

  a_pwm_full_duty: assert property (
    (op == PTM_OP_PWM && fn == PTM_FN_2 && run_q
      && ({1'b0, compare_a_value_q} >= ptm_limit(per_q)) && ({1'b0, cnt_q} < ptm_limit(per_q)))
      |=> timer_out == $past(lvl))
    else $error("full duty output not active");

  a_pulse_trigger: assert property ((op == PTM_OP_PULSE && trig_edge) |=> run_q)
    else $error("trigger edge did not set run");

  a_pulse_end: assert property (
    (op == PTM_OP_PULSE && a_hit && !trig_edge) |=> !run_q ##1 timer_out == !$past(lvl, 2))
    else $error("compare a match did not end pulse");

  a_pulse_restart: assert property ((op == PTM_OP_PULSE && run_rise) |=> cnt_q == '0)
    else $error("pulse counter not zero after start");

  a_cmp_init: assert property (
    (op == PTM_OP_CMP && run_rise) |=> cm_out_q == $past(ctrl_q.output_initial_level))
    else $error("compare output not restored on start");

  a_hold_stopped: assert property (!run_q |=> $stable(cnt_q))
    else $error("counter moved while stopped");

  a_flag_sticky: assert property ((a_hit && op == PTM_OP_PULSE) |=> compare_a_flag)
    else $error("pulse compare a flag lost");

endmodule

/* File: design/ptm_pkg.sv */
// Constants, types, register map and helper functions of the periodic timer
// Assumes an AHB-Lite master with 32-bit word accesses and one timer per module
package ptm_pkg;

  localparam int unsigned PTM_W_NARROW = 10;
  localparam int unsigned PTM_W_WIDE = 16;
  localparam int unsigned PTM_PRE_W = 7;

  localparam logic [7:0] PTM_OFF_CTRL = 8'h00;
  localparam logic [7:0] PTM_OFF_COMPA = 8'h04;
  localparam logic [7:0] PTM_OFF_PERIOD = 8'h08;
  localparam logic [7:0] PTM_OFF_COUNT = 8'h0c;
  localparam logic [7:0] PTM_OFF_FLAGS = 8'h10;
  localparam logic [7:0] PTM_OFF_STATUS = 8'h14;

  localparam int unsigned PTM_FLAG_A = 0;
  localparam int unsigned PTM_FLAG_P = 1;
  localparam int unsigned PTM_ST_PIN = 0;
  localparam int unsigned PTM_ST_OE = 1;

  localparam logic [11:0] PTM_CTRL_RST = 12'h000;
  localparam logic [1:0] PTM_FLAG_RST = 2'b00;

  localparam logic [1:0] PTM_MODE_CMP = 2'b00;
  localparam logic [1:0] PTM_MODE_PWM = 2'b10;
  localparam logic [1:0] PTM_MODE_TMR = 2'b11;

  // Output function codes: compare mode none/low/high/toggle,
  // PWM mode force low/force high/waveform, 11 with PWM code is single pulse
  localparam logic [1:0] PTM_FN_0 = 2'b00;
  localparam logic [1:0] PTM_FN_1 = 2'b01;
  localparam logic [1:0] PTM_FN_2 = 2'b10;
  localparam logic [1:0] PTM_FN_3 = 2'b11;

  localparam logic [2:0] PTM_HSIZE_WORD = 3'b010;

  typedef enum logic [1:0] {PTM_OP_CMP, PTM_OP_PWM, PTM_OP_PULSE, PTM_OP_TMR} ptm_op_e;

  typedef struct packed {
    logic [2:0] clk_sel;
    logic trig_fall;
    logic mode_select_hi;
    logic mode_select_lo;
    logic output_function_hi;
    logic output_function_lo;
    logic output_polarity_invert;
    logic output_initial_level;
    logic clear_source_select;
    logic counter_run;
  } ptm_ctrl_s;

  function automatic int unsigned ptm_width(input int unsigned inst);
    ptm_width = (inst == 2 || inst == 3) ? PTM_W_WIDE : PTM_W_NARROW;
  endfunction

  function automatic ptm_op_e ptm_decode(input logic [1:0] mode, input logic [1:0] fn);
    ptm_decode = PTM_OP_CMP;
    if (mode == PTM_MODE_TMR) begin
      ptm_decode = PTM_OP_TMR;
    end else if (mode == PTM_MODE_PWM) begin
      ptm_decode = (fn == PTM_FN_3) ? PTM_OP_PULSE : PTM_OP_PWM;
    end
  endfunction

  function automatic logic [PTM_PRE_W-1:0] ptm_tick_mask(input logic [2:0] sel);
    ptm_tick_mask = PTM_PRE_W'((8'h01 << sel) - 8'h01);
  endfunction

endpackage

/* File: design/ptm_sync_edge.sv */
// Two-flop synchroniser with edge detection for the trigger pin
// Assumes an asynchronous pin input and a select from the hclk domain
`timescale 1ns/1ps
module ptm_sync_edge (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic pin,
  input wire logic fall_sel,
  output logic edge_p
);

  logic s1_q;
  logic s2_q;
  logic s3_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end else begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // Only the settled stages feed the edge detector
  assign edge_p = fall_sel ? (s3_q & ~s2_q) : (s2_q & ~s3_q);

endmodule

/* File: verif/ptm_top_bench.sv */
// Self-checking bench for the periodic timer, driven over its AHB-Lite port
// Assumes the design package and a slave whose hreadyout feeds hready
`timescale 1ns/1ps
module ptm_top_bench;
  import ptm_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic trig = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] rd;
  logic [1:0] htrans = 2'b00;
  logic [2:0] hsize = PTM_HSIZE_WORD;
  wire logic hready, hresp, tout, toe, fa, fp;
  wire logic [31:0] hrdata;
  int mismatches = 0;
  int tests_run = 0;
  int c, p, d, n;
  logic init, pol;

  ptm_top #(.INST(0)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hready), .hresp(hresp), .hrdata(hrdata), .external_trigger_pin(trig),
    .timer_out(tout), .timer_out_oe(toe), .compare_a_flag(fa), .compare_p_flag(fp));

  initial begin
    forever #5 hclk = ~hclk;
  end

  task give_verdict;
    $display("Counts: %0d compared, %0d mismatches", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask

  task cyc(input int k);
    repeat (k) @(posedge hclk);
    #1;
  endtask

  // Bounded wait for hready at a rising edge
  task wait_rdy;
    int i;
    for (i = 0; i < 100; i++) begin
      @(posedge hclk);
      if (hready === 1'b1) break;
    end
    if (i == 100) begin
      mismatches++;
      $display("Error at %0t: bus wait timed out", $time);
      give_verdict();
    end
  endtask

  task bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    wait_rdy();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    check(32'(hresp), 32'h0);
  endtask

  task rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    check(rd, e);
  endtask

  function automatic logic [31:0] ctl(input logic [1:0] m, input logic [1:0] f,
    input logic pl, input logic in, input logic cl, input logic r);
    ctl = {24'h0, m, f, pl, in, cl, r};
  endfunction

  // Stop, clear both flags, then raise run with the given control word
  task start(input logic [31:0] cw);
    bus(1'b1, PTM_OFF_CTRL, cw & 32'hffff_fffe);
    bus(1'b1, PTM_OFF_FLAGS, 32'h3);
    bus(1'b1, PTM_OFF_CTRL, cw);
  endtask

  task wpin(input logic v, output int k);
    k = 0;
    while (tout !== v) begin
      @(posedge hclk);
      #1;
      k++;
      if (k > 70000) begin
        mismatches++;
        $display("Error at %0t: pin wait timed out", $time);
        give_verdict();
      end
    end
  endtask

  task lvl(input logic v, input int k, output int cnt);
    cnt = 0;
    repeat (k) begin
      @(posedge hclk);
      #1;
      if (tout === v) cnt++;
    end
  endtask

  // Cycles from one active edge of the pin to the next
  task per(input logic a, output int k);
    int k1;
    wpin(~a, k1);
    wpin(a, k1);
    wpin(~a, k1);
    wpin(a, k);
    k = k + k1;
  endtask

  initial begin
    void'($urandom(32'he4c7030b));
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    cyc(1);
    check(32'(toe), 32'h1);
    rchk(PTM_OFF_CTRL, 32'h0);
    rchk(PTM_OFF_FLAGS, 32'h0);
    rchk(PTM_OFF_COUNT, 32'h0);
    rchk(8'h18, 32'h0);
    bus(1'b1, PTM_OFF_COMPA, 32'hffff);
    rchk(PTM_OFF_COMPA, 32'h3ff);
    // Timer/counter mode, both clear sources
    bus(1'b1, PTM_OFF_PERIOD, 32'h7);
    bus(1'b1, PTM_OFF_COMPA, 32'h3);
    start(ctl(PTM_MODE_TMR, PTM_FN_2, 1'b0, 1'b0, 1'b0, 1'b1));
    cyc(30);
    check(32'(toe), 32'h0);
    rchk(PTM_OFF_FLAGS, 32'h3);
    start(ctl(PTM_MODE_TMR, PTM_FN_0, 1'b0, 1'b0, 1'b1, 1'b1));
    cyc(30);
    rchk(PTM_OFF_FLAGS, 32'h1);
    // PWM with random period, duty and polarity, corners first
    for (int i = 0; i < 8; i++) begin
      p = 2 + $urandom % 10;
      d = (i == 0) ? p : (i == 1) ? p + 5 : (i == 2) ? 0 : 1 + $urandom % p;
      init = 1'($urandom);
      pol = 1'($urandom);
      bus(1'b1, PTM_OFF_PERIOD, 32'(p));
      bus(1'b1, PTM_OFF_COMPA, 32'(d));
      start(ctl(PTM_MODE_PWM, PTM_FN_2, pol, init, 1'($urandom), 1'b1));
      cyc(2 * p + 4);
      lvl(init ^ pol, 3 * p, c);
      check(32'(c), 32'(3 * (d < p ? d : p)));
      rchk(PTM_OFF_FLAGS, {30'h0, 1'b1, (d >= 1 && d <= p)});
      check(32'({fp, fa}), {30'h0, 1'b1, (d >= 1 && d <= p)});
      if (d > 0 && d < p) begin
        per(init ^ pol, c);
        check(32'(c), 32'(p));
      end
    end
    bus(1'b1, PTM_OFF_PERIOD, 32'h0);
    bus(1'b1, PTM_OFF_COMPA, 32'h1);
    start(ctl(PTM_MODE_PWM, PTM_FN_2, 1'b0, 1'b1, 1'b0, 1'b1));
    per(1'b1, c);
    check(32'(c), 32'h400);
    // Forced pin levels while the counter keeps running
    bus(1'b1, PTM_OFF_PERIOD, 32'h5);
    bus(1'b1, PTM_OFF_COMPA, 32'h2);
    for (int f = 0; f < 2; f++) begin
      start(ctl(PTM_MODE_PWM, 2'(f), 1'b0, 1'b0, 1'b0, 1'b1));
      cyc(3);
      lvl(1'(f), 20, c);
      check(32'(c), 32'h14);
      rchk(PTM_OFF_FLAGS, 32'h3);
    end
    // Timer clock at half rate doubles the period
    start(ctl(PTM_MODE_PWM, PTM_FN_2, 1'b0, 1'b0, 1'b0, 1'b1) | 32'h200);
    per(1'b0, c);
    check(32'(c), 32'ha);
    // Single pulse by software, period below width
    n = 4 + $urandom % 16;
    bus(1'b1, PTM_OFF_PERIOD, 32'h2);
    bus(1'b1, PTM_OFF_COMPA, 32'(n));
    bus(1'b1, PTM_OFF_CTRL, ctl(PTM_MODE_PWM, PTM_FN_3, 1'b0, 1'b1, 1'b1, 1'b0));
    cyc(2);
    check(32'(tout), 32'h0);
    start(ctl(PTM_MODE_PWM, PTM_FN_3, 1'b0, 1'b1, 1'b1, 1'b1));
    wpin(1'b1, c);
    check(32'(c < 4), 32'h1);
    wpin(1'b0, c);
    check(32'(c >= n && c <= n + 2), 32'h1);
    rchk(PTM_OFF_CTRL, ctl(PTM_MODE_PWM, PTM_FN_3, 1'b0, 1'b1, 1'b1, 1'b0));
    bus(1'b0, PTM_OFF_FLAGS, 32'h0);
    check(rd & 32'h1, 32'h1);
    check(32'(fa), 32'h1);
    rchk(PTM_OFF_COUNT, 32'(n));
    // Trigger pin restarts the pulse
    trig <= 1'b1;
    wpin(1'b1, c);
    check(32'(c < 8), 32'h1);
    wpin(1'b0, c);
    check(32'(c >= n && c <= n + 2), 32'h1);
    rchk(PTM_OFF_COUNT, 32'(n));
    // Falling edge select, pin released low
    bus(1'b1, PTM_OFF_CTRL,
      ctl(PTM_MODE_PWM, PTM_FN_3, 1'b0, 1'b1, 1'b1, 1'b0) | 32'h100);
    trig <= 1'b0;
    wpin(1'b1, c);
    check(32'(c < 8), 32'h1);
    wpin(1'b0, c);
    check(32'(c >= n && c <= n + 2), 32'h1);
    // Software ends a long pulse early
    bus(1'b1, PTM_OFF_COMPA, 32'h3ff);
    start(ctl(PTM_MODE_PWM, PTM_FN_3, 1'b0, 1'b1, 1'b0, 1'b1));
    cyc(6);
    bus(1'b1, PTM_OFF_CTRL, ctl(PTM_MODE_PWM, PTM_FN_3, 1'b0, 1'b1, 1'b0, 1'b0));
    wpin(1'b0, c);
    check(32'(c < 4), 32'h1);
    // Compare mode restores the initial level on run rising
    bus(1'b1, PTM_OFF_PERIOD, 32'h40);
    bus(1'b1, PTM_OFF_COMPA, 32'h8);
    start(ctl(PTM_MODE_CMP, PTM_FN_1, 1'b0, 1'b1, 1'b0, 1'b1));
    cyc(3);
    check(32'(tout), 32'h1);
    cyc(12);
    check(32'(tout), 32'h0);
    // Compare toggle with clear on compare A
    start(ctl(PTM_MODE_CMP, PTM_FN_3, 1'b0, 1'b0, 1'b1, 1'b1));
    per(1'b1, c);
    check(32'(c), 32'h10);
    give_verdict();
  end
endmodule
